// ---- logic/nfh_pkg.sv ----
package nfh_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int POWERUP_NS = 10_000;
  localparam int POWERUP_CYC = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_NS = 25;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int BUSY_DELAY_NS = 100;
  localparam int BUSY_DELAY_CYC = (BUSY_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_LOW_CYC = STROBE_CYC + 3;
  localparam int CNT_W = 9;

  //////////////////////////////////////////////////////////////////////////////
  // Flash command bytes
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_IDENTIFY = 8'h90;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] IDENTIFY_ADDR = 8'h00;

  // Flash status byte fields
  localparam int ST_FAIL_BIT = 0;
  localparam int ST_READY_BIT = 6;
  localparam int ST_WP_BIT = 7;
  localparam logic [7:0] ST_RESET_VAL = 8'hC0;

  // Block address is row bits A14..A24; A9..A13 sent as zero
  localparam int BLOCK_W = 11;
  localparam int PAGE_BITS = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Controller registers (byte offsets)
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BLOCK = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_ID = 8'h10;
  localparam logic [7:0] REG_LAST = REG_ID;
  localparam logic CTRL_WP_RESET = 1'b0;
  localparam logic [BLOCK_W-1:0] BLOCK_RESET = 11'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // STATUS register fields
  localparam int SR_BUSY = 0;
  localparam int SR_POWER_OK = 1;
  localparam int SR_RB = 2;
  localparam int SR_REFUSED = 3;
  localparam int SR_FAIL = 4;
  localparam int SR_FLASH_LSB = 8;

  typedef enum logic [2:0] {
    OpNone = 3'h0,
    OpErase = 3'h1,
    OpStatus = 3'h2,
    OpIdentify = 3'h3,
    OpReset = 3'h4
  } nfh_op_t;

  typedef enum logic [2:0] {ActCmd, ActAddr, ActRead, ActWait, ActEnd} nfh_act_t;

  function automatic logic regMapped(input logic [ADDR_W-1:0] addr);
    regMapped = (addr[1:0] == 2'h0) && (addr <= REG_LAST);
  endfunction : regMapped

endpackage : nfh_pkg

// ---- logic/nfh_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module nfh_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  // Two flops; the first is read only by the second
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stage1_q <= '0;
      syncOut <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut <= stage1_q;
    end
  end

endmodule : nfh_sync
`default_nettype wire

// ---- logic/nfh_axil_slave.sv ----
`timescale 1ns/1ns
`default_nettype none
module nfh_axil_slave (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [nfh_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [nfh_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic regWe,
  output logic [nfh_pkg::ADDR_W-1:0] regWaddr,
  output logic [31:0] regWdata,
  output logic [3:0] regWstrb,
  output logic [nfh_pkg::ADDR_W-1:0] regRaddr,
  input wire logic [31:0] regRdata
);

  logic awHeld_q;
  logic wHeld_q;
  logic [nfh_pkg::ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic doWrite;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  assign regWe = doWrite && nfh_pkg::regMapped(awAddr_q);
  assign regWaddr = awAddr_q;
  assign regWdata = wData_q;
  assign regWstrb = wStrb_q;
  assign regRaddr = s_axi_araddr;

  //////////////////////////////////////////////////////////////////////////////
  // Write address and data, taken in either order
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
    end else if (doWrite) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= nfh_pkg::RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= nfh_pkg::regMapped(awAddr_q) ? nfh_pkg::RESP_OKAY : nfh_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel, answer one cycle after the address
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= nfh_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= nfh_pkg::regMapped(s_axi_araddr) ? regRdata : 32'h0000_0000;
      s_axi_rresp <= nfh_pkg::regMapped(s_axi_araddr) ? nfh_pkg::RESP_OKAY : nfh_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : nfh_axil_slave
`default_nettype wire

// ---- logic/nfh_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Erase: setup command then two address cycles
// - Erase runs only after the confirm command
// - Status mode lasts until a new command
// - Identify command plus one zero address cycle
// - Wait 10 us after power-up; hold protect low (protect follows CTRL bit 0, low from reset but writable during the wait)
module nfh_ctrl (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [nfh_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [nfh_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic chipSelN,
  output logic cmdLatch,
  output logic addrLatch,
  output logic writeStrobeN,
  output logic read_strobe_n,
  output logic writeProtectN,
  output logic [7:0] ioOut,
  output logic ioOe,
  input wire logic [7:0] ioIn,
  input wire logic readyBusyIn
);

  typedef enum {StPower, StIdle, StFetch, StLow, StHigh, StWaitDelay, StWaitReady} nfh_state_t;

  nfh_state_t state_q;
  nfh_pkg::nfh_op_t op_q;
  nfh_pkg::nfh_act_t act;
  logic [3:0] step_q;
  logic [nfh_pkg::CNT_W-1:0] cnt_q;
  logic readIdx_q;
  logic wpN_q;
  logic [nfh_pkg::BLOCK_W-1:0] block_q;
  logic refused_q;
  logic [7:0] flashStatus_q;
  logic [7:0] makerId_q;
  logic [7:0] deviceId_q;
  logic [7:0] stepByte;
  logic [15:0] rowAddr;
  logic regWe;
  logic [nfh_pkg::ADDR_W-1:0] regWaddr;
  logic [31:0] regWdata;
  logic [3:0] regWstrb;
  logic [nfh_pkg::ADDR_W-1:0] regRaddr;
  logic [31:0] regRdata;
  logic [7:0] ioSync;
  logic readyBusySync;
  logic startOp;
  nfh_pkg::nfh_op_t reqOp;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave and pin synchronisers
  nfh_axil_slave uSlave (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regWe(regWe),
    .regWaddr(regWaddr),
    .regWdata(regWdata),
    .regWstrb(regWstrb),
    .regRaddr(regRaddr),
    .regRdata(regRdata)
  );

  nfh_sync #(.WIDTH(9)) uSync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn({readyBusyIn, ioIn}),
    .syncOut({readyBusySync, ioSync})
  );

  //////////////////////////////////////////////////////////////////////////////
  // Command sequences, one action per step
  function automatic nfh_pkg::nfh_act_t stepAct(input nfh_pkg::nfh_op_t op, input logic [3:0] step);
    stepAct = nfh_pkg::ActEnd;
    unique case (op)
      nfh_pkg::OpErase: begin
        unique case (step)
          4'h0, 4'h3, 4'h5: stepAct = nfh_pkg::ActCmd;
          4'h1, 4'h2: stepAct = nfh_pkg::ActAddr;
          4'h4: stepAct = nfh_pkg::ActWait;
          4'h6: stepAct = nfh_pkg::ActRead;
          default: stepAct = nfh_pkg::ActEnd;
        endcase
      end
      nfh_pkg::OpStatus: begin
        stepAct = (step == 4'h0) ? nfh_pkg::ActCmd :
                  (step == 4'h1) ? nfh_pkg::ActRead : nfh_pkg::ActEnd;
      end
      nfh_pkg::OpIdentify: begin
        unique case (step)
          4'h0: stepAct = nfh_pkg::ActCmd;
          4'h1: stepAct = nfh_pkg::ActAddr;
          4'h2, 4'h3: stepAct = nfh_pkg::ActRead;
          default: stepAct = nfh_pkg::ActEnd;
        endcase
      end
      nfh_pkg::OpReset: begin
        stepAct = (step == 4'h0) ? nfh_pkg::ActCmd :
                  (step == 4'h1) ? nfh_pkg::ActWait : nfh_pkg::ActEnd;
      end
      default: stepAct = nfh_pkg::ActEnd;
    endcase
  endfunction : stepAct

  assign rowAddr = {block_q, {nfh_pkg::PAGE_BITS{1'b0}}};
  assign act = stepAct(op_q, step_q);

  always_comb begin
    stepByte = 8'h00;
    unique case (op_q)
      nfh_pkg::OpErase: begin
        unique case (step_q)
          4'h0: stepByte = nfh_pkg::CMD_ERASE_SETUP;
          4'h1: stepByte = rowAddr[7:0];
          4'h2: stepByte = rowAddr[15:8];
          4'h3: stepByte = nfh_pkg::CMD_ERASE_CONFIRM;
          default: stepByte = nfh_pkg::CMD_STATUS;
        endcase
      end
      nfh_pkg::OpStatus: stepByte = nfh_pkg::CMD_STATUS;
      nfh_pkg::OpIdentify: begin
        stepByte = (step_q == 4'h0) ? nfh_pkg::CMD_IDENTIFY : nfh_pkg::IDENTIFY_ADDR;
      end
      nfh_pkg::OpReset: stepByte = nfh_pkg::CMD_RESET;
      default: stepByte = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers
  assign reqOp = nfh_pkg::nfh_op_t'(regWdata[2:0]);
  assign startOp = regWe && (regWaddr == nfh_pkg::REG_CMD) && regWstrb[0] && (state_q == StIdle)
                   && readyBusySync && (reqOp != nfh_pkg::OpNone) && (regWdata[2:0] <= 3'h4);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wpN_q <= nfh_pkg::CTRL_WP_RESET;
      block_q <= nfh_pkg::BLOCK_RESET;
    end else if (regWe) begin
      if (regWaddr == nfh_pkg::REG_CTRL && regWstrb[0]) begin
        wpN_q <= regWdata[0];
      end
      if (regWaddr == nfh_pkg::REG_BLOCK && regWstrb[0]) begin
        block_q[7:0] <= regWdata[7:0];
      end
      if (regWaddr == nfh_pkg::REG_BLOCK && regWstrb[1]) begin
        block_q[10:8] <= regWdata[10:8];
      end
    end
  end

  // Refused command flag, cleared by the next accepted command
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      refused_q <= 1'b0;
    end else if (regWe && regWaddr == nfh_pkg::REG_CMD && regWstrb[0]) begin
      refused_q <= !startOp;
    end
  end

  always_comb begin
    regRdata = 32'h0000_0000;
    unique case (regRaddr)
      nfh_pkg::REG_CTRL: regRdata[0] = wpN_q;
      nfh_pkg::REG_BLOCK: regRdata[nfh_pkg::BLOCK_W-1:0] = block_q;
      nfh_pkg::REG_STATUS: begin
        regRdata[nfh_pkg::SR_BUSY] = (state_q != StIdle);
        regRdata[nfh_pkg::SR_POWER_OK] = (state_q != StPower);
        regRdata[nfh_pkg::SR_RB] = readyBusySync;
        regRdata[nfh_pkg::SR_REFUSED] = refused_q;
        regRdata[nfh_pkg::SR_FAIL] = flashStatus_q[nfh_pkg::ST_FAIL_BIT];
        regRdata[nfh_pkg::SR_FLASH_LSB +: 8] = flashStatus_q;
      end
      nfh_pkg::REG_ID: regRdata[15:0] = {deviceId_q, makerId_q};
      default: regRdata = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= StPower;
      op_q <= nfh_pkg::OpNone;
      step_q <= 4'h0;
      cnt_q <= nfh_pkg::CNT_W'(nfh_pkg::POWERUP_CYC);
      readIdx_q <= 1'b0;
    end else begin
      unique case (state_q)
        StPower: begin
          if (cnt_q == '0) begin
            state_q <= StIdle;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        StIdle: begin
          if (startOp) begin
            op_q <= reqOp;
            step_q <= 4'h0;
            readIdx_q <= 1'b0;
            state_q <= StFetch;
          end
        end
        StFetch: begin
          unique case (act)
            nfh_pkg::ActCmd, nfh_pkg::ActAddr: begin
              cnt_q <= nfh_pkg::CNT_W'(nfh_pkg::STROBE_CYC);
              state_q <= StLow;
            end
            nfh_pkg::ActRead: begin
              cnt_q <= nfh_pkg::CNT_W'(nfh_pkg::READ_LOW_CYC);
              state_q <= StLow;
            end
            nfh_pkg::ActWait: begin
              cnt_q <= nfh_pkg::CNT_W'(nfh_pkg::BUSY_DELAY_CYC);
              state_q <= StWaitDelay;
            end
            nfh_pkg::ActEnd: state_q <= StIdle;
          endcase
        end
        StLow: begin
          if (cnt_q <= 1) begin
            cnt_q <= nfh_pkg::CNT_W'(nfh_pkg::STROBE_CYC);
            state_q <= StHigh;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
          if (cnt_q <= 1 && act == nfh_pkg::ActRead) begin
            readIdx_q <= !readIdx_q;
          end
        end
        StHigh: begin
          if (cnt_q <= 1) begin
            step_q <= step_q + 1'b1;
            state_q <= StFetch;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        StWaitDelay: begin
          if (cnt_q <= 1) begin
            state_q <= StWaitReady;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        StWaitReady: begin
          if (readyBusySync) begin
            step_q <= step_q + 1'b1;
            state_q <= StFetch;
          end
        end
      endcase
    end
  end

  // Bytes read back from the flash
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      flashStatus_q <= nfh_pkg::ST_RESET_VAL;
      makerId_q <= 8'h00;
      deviceId_q <= 8'h00;
    end else if (state_q == StLow && cnt_q <= 1 && act == nfh_pkg::ActRead) begin
      if (op_q == nfh_pkg::OpIdentify) begin
        if (readIdx_q) begin
          deviceId_q <= ioSync;
        end else begin
          makerId_q <= ioSync;
        end
      end else begin
        flashStatus_q <= ioSync;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flash pins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      chipSelN <= 1'b1;
      cmdLatch <= 1'b0;
      addrLatch <= 1'b0;
      writeStrobeN <= 1'b1;
      read_strobe_n <= 1'b1;
      ioOut <= 8'h00;
      ioOe <= 1'b0;
    end else begin
      chipSelN <= (state_q == StIdle || state_q == StPower) && !startOp;
      if (state_q == StFetch) begin
        cmdLatch <= (act == nfh_pkg::ActCmd);
        addrLatch <= (act == nfh_pkg::ActAddr);
        writeStrobeN <= !(act == nfh_pkg::ActCmd || act == nfh_pkg::ActAddr);
        read_strobe_n <= (act != nfh_pkg::ActRead);
        ioOe <= (act == nfh_pkg::ActCmd || act == nfh_pkg::ActAddr);
        ioOut <= stepByte;
      end else if (state_q == StLow && cnt_q <= 1) begin
        writeStrobeN <= 1'b1;
        read_strobe_n <= 1'b1;
      end else if (state_q != StHigh && state_q != StLow) begin
        cmdLatch <= 1'b0;
        addrLatch <= 1'b0;
        ioOe <= 1'b0;
      end
    end
  end

  assign writeProtectN = wpN_q;

endmodule : nfh_ctrl
`default_nettype wire

// ---- verif/nfh_ctrl_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module nfh_ctrl_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic chipSelN,
  input wire logic cmdLatch,
  input wire logic addrLatch,
  input wire logic writeStrobeN,
  input wire logic read_strobe_n,
  input wire logic [7:0] ioOut,
  input wire logic ioOe,
  input wire logic readyBusyIn
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [8:0] pwrCnt_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst) pwrCnt_q <= 9'h000;
    else if (pwrCnt_q != 9'h0F8) pwrCnt_q <= pwrCnt_q + 9'h001;
  end
  //////////////////////////////////////////////////////////////////////////////
  a_power_wait: assert property (pwrCnt_q < 9'h0F8 |-> chipSelN)
    else $error("flash selected during power-up wait");
  a_reset_idle: assert property (@(posedge core_clk) disable iff (1'b0)
    sys_rst |=> chipSelN && writeStrobeN && read_strobe_n && !ioOe)
    else $error("flash pins not idle after reset");
  a_we_pulse: assert property ($fell(writeStrobeN) |-> !chipSelN && ioOe ##1 writeStrobeN)
    else $error("write strobe pulse malformed");
  a_latch_held: assert property ($rose(writeStrobeN) |-> ioOe && $stable(ioOut)
    && $stable(cmdLatch) && $stable(addrLatch))
    else $error("byte not held at write strobe rise");
  a_latch_excl: assert property (!(cmdLatch && addrLatch))
    else $error("command and address latch both high");
  a_read_len: assert property ($fell(read_strobe_n) |->
    (!read_strobe_n && !chipSelN && !ioOe)[*4] ##1 read_strobe_n)
    else $error("read strobe low time wrong");
  a_cmd_ready: assert property ($fell(chipSelN) |-> $past(readyBusyIn, 3))
    else $error("sequence started while flash busy");
  a_erase_addr: assert property ($rose(writeStrobeN) && cmdLatch && ioOut == 8'h60 |->
    ##[1:8] $rose(writeStrobeN) && addrLatch && ioOut[4:0] == 5'h00)
    else $error("erase setup not followed by block address");
  a_id_addr: assert property ($rose(writeStrobeN) && cmdLatch && ioOut == 8'h90 |->
    ##[1:8] $rose(writeStrobeN) && addrLatch && ioOut == 8'h00)
    else $error("identify not followed by zero address");
  c_confirm: cover property ($rose(writeStrobeN) && cmdLatch && ioOut == 8'hD0);
  c_reset: cover property ($rose(writeStrobeN) && cmdLatch && ioOut == 8'hFF);
  c_read: cover property ($fell(read_strobe_n));
endmodule : nfh_ctrl_monitor
bind nfh_ctrl nfh_ctrl_monitor u_mon (.core_clk(core_clk), .sys_rst(sys_rst),
  .chipSelN(chipSelN), .cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeStrobeN(writeStrobeN),
  .read_strobe_n(read_strobe_n), .ioOut(ioOut), .ioOe(ioOe), .readyBusyIn(readyBusyIn));
`default_nettype wire

// ---- verif/nfh_flash_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module nfh_flash_model #(
  parameter logic [7:0] MAKER = 8'h3C, // Arbitrary value
  parameter logic [7:0] DEVICE = 8'hA7, // Arbitrary value
  parameter int BUSY_NS = 2000
) (
  input wire logic chipSelN,
  input wire logic cmdLatch,
  input wire logic addrLatch,
  input wire logic writeStrobeN,
  input wire logic read_strobe_n,
  input wire logic writeProtectN,
  input wire logic [7:0] ioOut,
  input wire logic ioOe,
  input wire logic failSet,
  output logic [7:0] ioIn,
  output logic readyBusyIn,
  output var logic [15:0] rowSeen,
  output var logic [7:0] eraseCnt
);
  logic busy, fail, nextFail, idSel;
  logic [2:0] mode;
  logic [1:0] nAddr;
  logic [7:0] st, outVal, lastOut;
  event opStart;
  initial begin
    {busy, fail, nextFail, idSel, mode, nAddr, lastOut} = '0;
    rowSeen = 16'h0000;
    eraseCnt = 8'h00;
  end
  assign st = {writeProtectN, !busy, 5'h00, fail};
  assign outVal = (mode == 3'h2) ? (idSel ? DEVICE : MAKER) : st;
  assign ioIn = (!chipSelN && !read_strobe_n && !ioOe) ? outVal : ~lastOut;
  assign readyBusyIn = !busy;
  always @(posedge read_strobe_n) begin
    lastOut = outVal;
    if (mode == 3'h2) idSel = 1'b1;
  end
  always @(opStart) begin
    #(BUSY_NS);
    busy = 1'b0;
    fail = nextFail;
  end
  always @(posedge writeStrobeN) begin
    if (!chipSelN && cmdLatch && (!busy || ioOut == 8'h70 || ioOut == 8'hFF)) begin
      case (ioOut)
        8'h60: begin mode = 3'h3; nAddr = 2'h0; end
        8'hD0: if (mode == 3'h3 && nAddr == 2'h2) begin
          eraseCnt = eraseCnt + 8'h01;
          nextFail = failSet;
          busy = 1'b1;
          ->opStart;
        end
        8'h70: mode = 3'h1;
        8'h90: begin mode = 3'h2; idSel = 1'b0; nAddr = 2'h0; end
        8'hFF: if (mode != 3'h4) begin
          mode = 3'h4;
          nextFail = 1'b0;
          busy = 1'b1;
          ->opStart;
        end
        default: mode = 3'h0;
      endcase
    end else if (!chipSelN && addrLatch && !busy) begin
      if (nAddr == 2'h0) rowSeen[7:0] = ioOut;
      else rowSeen[15:8] = ioOut;
      nAddr = nAddr + 2'h1;
    end
  end
endmodule : nfh_flash_model
`default_nettype wire

// ---- verif/test_nfh_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_nfh_ctrl;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
  localparam logic [7:0] DEVICE = 8'hA7; // Arbitrary value
  localparam logic [31:0] MASK = 32'h0000FF1F;
  logic core_clk, sys_rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, chipSelN, cmdLatch, addrLatch, writeStrobeN;
  logic read_strobe_n, writeProtectN, ioOe, readyBusyIn, failSet;
  logic [7:0] awaddr, araddr, ioIn, ioOut, eraseCnt;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] rowSeen;
  int n_errors, num_checks, i;
  nfh_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .chipSelN(chipSelN), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
    .writeStrobeN(writeStrobeN), .read_strobe_n(read_strobe_n), .writeProtectN(writeProtectN),
    .ioOut(ioOut), .ioOe(ioOe), .ioIn(ioIn), .readyBusyIn(readyBusyIn));
  nfh_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE), .BUSY_NS(2010)) u_flash (
    .chipSelN(chipSelN), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
    .writeStrobeN(writeStrobeN), .read_strobe_n(read_strobe_n), .writeProtectN(writeProtectN),
    .ioOut(ioOut), .ioOe(ioOe), .failSet(failSet), .ioIn(ioIn), .readyBusyIn(readyBusyIn),
    .rowSeen(rowSeen), .eraseCnt(eraseCnt));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask : axr
  task automatic poll;
    int k;
    k = 0;
    do begin
      axr(nfh_pkg::REG_STATUS);
      k++;
    end while (rd[nfh_pkg::SR_BUSY] !== 1'b0 && k < 400);
    chk({31'h0, rd[nfh_pkg::SR_BUSY]}, 32'h00000000);
  endtask : poll
  task automatic cmd(input logic [31:0] c);
    axw(nfh_pkg::REG_CMD, c);
    poll();
  endtask : cmd
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    n_errors++;
    summarize();
  end
  initial begin
    {n_errors, num_checks} = '0;
    {awvalid, wvalid, bready, arvalid, rready, failSet} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    sys_rst = 1'b1;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    axr(nfh_pkg::REG_CTRL); chk(rd, 32'h00000000);
    axr(nfh_pkg::REG_STATUS); chk(rd & MASK, 32'h0000C005);
    axw(nfh_pkg::REG_CMD, 32'h00000002);
    axr(nfh_pkg::REG_STATUS); chk(rd & MASK, 32'h0000C00D);
    $display("test power-up done");
    repeat (260) @(posedge core_clk);
    axr(8'h14); chk({30'h0, resp}, {30'h0, nfh_pkg::RESP_SLVERR});
    axw(8'h06, 32'h00000001); chk({30'h0, resp}, {30'h0, nfh_pkg::RESP_SLVERR});
    $display("test unmapped done");
    for (i = 0; i < 2; i++) begin
      axw(nfh_pkg::REG_CTRL, 32'(i));
      cmd(32'h00000002); chk(rd & MASK, {16'h0, i[0], 7'h40, 8'h06});
    end
    $display("test status done");
    cmd(32'h00000003);
    axr(nfh_pkg::REG_ID); chk(rd & 32'h0000FFFF, {16'h0, DEVICE, MAKER});
    $display("test identify done");
    axw(nfh_pkg::REG_BLOCK, 32'h000005A5);
    cmd(32'h00000001); chk(rd & MASK, 32'h0000C006);
    chk({16'h0, rowSeen}, {16'h0, 11'h5A5, 5'h00});
    failSet <= 1'b1;
    axw(nfh_pkg::REG_BLOCK, 32'h0000002A);
    axw(nfh_pkg::REG_CMD, 32'h00000001);
    axw(nfh_pkg::REG_CMD, 32'h00000002);
    poll(); chk(rd & MASK, 32'h0000C11E);
    chk({24'h0, eraseCnt}, 32'h00000002);
    $display("test erase done");
    failSet <= 1'b0;
    cmd(32'h00000004);
    cmd(32'h00000002); chk(rd & MASK, 32'h0000C006);
    cmd(32'h00000007); chk(rd & MASK, 32'h0000C00E);
    $display("test reset done");
    summarize();
  end
endmodule : test_nfh_ctrl
`default_nettype wire
